// *** hdl/clock_source_reset_select.sv ***
// Operation
// - Straps pick crystal or external PLL references
// - Each clock pin chooses one of five clocks
// - Reset aborts all work, defined state
// - Reset output is AND of three resets
// - Battery fault blocks wake from sleep
// - Drive core power enable from power state
`timescale 1ns/100ps
module clock_source_reset_select #(
	parameter int unsigned NUM_CLK_OUT = 2 // Clock-output pins
) (
	input  wire logic                                           clk,              // Core clock
	input  wire logic                                           reset,            // Sync reset, high
	input  wire logic                                           resetInputN,      // External reset, low
	input  wire logic                                           watchdogResetN,   // Watchdog reset, low
	input  wire logic                                           softwareResetReq, // Active low
	input  wire logic [1:0]                                     clockModeStraps,  // Mode straps
	input  wire logic                                           batteryFaultN,    // Low battery, low
	input  wire logic                                           sleepReq,         // Enter sleep
	input  wire logic                                           wakeReq,          // Wake request
	input  wire clock_source_reset_select_pkg::clock_taps_s     clockTaps,        // Source clocks
	input  wire logic [NUM_CLK_OUT*3-1:0]                       clockOutSelect,   // Select fields
	output logic [NUM_CLK_OUT-1:0]                              clockOutputPin,   // Clock outputs
	output clock_source_reset_select_pkg::pll_refs_s            pllRefs,          // PLL references
	output logic                                                resetOutputN,     // External reset
	output logic                                                corePowerEnable,  // Core supply on
	output logic                                                asleep            // In sleep
);

	// Refuse pin counts and select widths that the logic cannot serve
	generate
		if (NUM_CLK_OUT < 1 || clock_source_reset_select_pkg::CLK_SEL_W != 3) begin : g_bad_param
			$error("clock_source_reset_select: bad parameter");
		end
	endgenerate

	// ****************************************************************
	// Reset combination
	// ****************************************************************
	logic anyReset;
	assign anyReset = reset | ~resetInputN;

	logic resetOutputN_r;
	always_ff @(posedge clk) begin
		if (reset)
			resetOutputN_r <= 1'h0;
		else
			resetOutputN_r <= resetInputN & watchdogResetN & softwareResetReq;
	end
	assign resetOutputN = resetOutputN_r;

	// ****************************************************************
	// Strap capture
	// ****************************************************************
	clock_source_reset_select_pkg::pll_refs_s pllRefs_r;
	always_ff @(posedge clk) begin
		if (anyReset) begin
			case (clockModeStraps)
				clock_source_reset_select_pkg::STRAP_XTAL_BOTH: begin
					pllRefs_r <= {clock_source_reset_select_pkg::REF_CRYSTAL,
						clock_source_reset_select_pkg::REF_CRYSTAL};
				end
				clock_source_reset_select_pkg::STRAP_XTAL_MAIN: begin
					pllRefs_r <= {clock_source_reset_select_pkg::REF_CRYSTAL,
						clock_source_reset_select_pkg::REF_EXTERNAL};
				end
				clock_source_reset_select_pkg::STRAP_EXT_MAIN: begin
					pllRefs_r <= {clock_source_reset_select_pkg::REF_EXTERNAL,
						clock_source_reset_select_pkg::REF_CRYSTAL};
				end
				default: begin
					pllRefs_r <= {clock_source_reset_select_pkg::REF_EXTERNAL,
						clock_source_reset_select_pkg::REF_EXTERNAL};
				end
			endcase
		end
	end
	assign pllRefs = pllRefs_r;

	// ****************************************************************
	// Clock-output selection
	// ****************************************************************
	logic [NUM_CLK_OUT-1:0] clockOutputPin_r;
	genvar i;
	generate
		for (i = 0; i < NUM_CLK_OUT; i++) begin : g_out
			always_ff @(posedge clk) begin
				if (anyReset)
					clockOutputPin_r[i] <= 1'h0;
				else begin
					case (clockOutSelect[i*3 +: 3])
						clock_source_reset_select_pkg::SEL_MAIN_PLL:
							clockOutputPin_r[i] <= clockTaps.mainPll;
						clock_source_reset_select_pkg::SEL_USB_PLL:
							clockOutputPin_r[i] <= clockTaps.usbPll;
						clock_source_reset_select_pkg::SEL_CORE:
							clockOutputPin_r[i] <= clockTaps.core;
						clock_source_reset_select_pkg::SEL_SYS_BUS:
							clockOutputPin_r[i] <= clockTaps.sysBus;
						default:
							clockOutputPin_r[i] <= clockTaps.periBus;
					endcase
				end
			end
		end
	endgenerate
	assign clockOutputPin = clockOutputPin_r;

	// ****************************************************************
	// Power state
	// ****************************************************************
	clock_source_reset_select_pkg::power_state_e state_r;
	always_ff @(posedge clk) begin
		if (anyReset)
			state_r <= clock_source_reset_select_pkg::PWR_ON;
		else begin
			case (state_r)
				clock_source_reset_select_pkg::PWR_ON:
					if (sleepReq)
						state_r <= clock_source_reset_select_pkg::PWR_SLEEP;
				clock_source_reset_select_pkg::PWR_SLEEP:
					if (wakeReq && batteryFaultN)
						state_r <= clock_source_reset_select_pkg::PWR_WAKE;
				clock_source_reset_select_pkg::PWR_WAKE:
					state_r <= clock_source_reset_select_pkg::PWR_ON;
				default:
					state_r <= clock_source_reset_select_pkg::PWR_ON;
			endcase
		end
	end

	logic corePowerEnable_r;
	logic asleep_r;
	always_ff @(posedge clk) begin
		if (anyReset) begin
			corePowerEnable_r <= 1'h1;
			asleep_r <= 1'h0;
		end else begin
			corePowerEnable_r <= (state_r != clock_source_reset_select_pkg::PWR_SLEEP);
			asleep_r <= (state_r == clock_source_reset_select_pkg::PWR_SLEEP);
		end
	end
	assign corePowerEnable = corePowerEnable_r;
	assign asleep = asleep_r;

endmodule

// *** hdl/clock_source_reset_select_pkg.sv ***
package clock_source_reset_select_pkg;

	// ****************************************************************
	// Strap encodings and PLL reference choices
	// ****************************************************************
	localparam logic [1:0] STRAP_XTAL_BOTH  = 2'h0;
	localparam logic [1:0] STRAP_XTAL_MAIN  = 2'h1;
	localparam logic [1:0] STRAP_EXT_MAIN   = 2'h2;
	localparam logic [1:0] STRAP_EXT_BOTH   = 2'h3;
	localparam logic [1:0] STRAP_RESET_VAL  = 2'h0;

	localparam logic REF_CRYSTAL = 1'h0;
	localparam logic REF_EXTERNAL = 1'h1;

	// ****************************************************************
	// Clock-output select field
	// ****************************************************************
	localparam int unsigned CLK_SEL_W = 3;
	localparam logic [2:0] SEL_MAIN_PLL = 3'h0;
	localparam logic [2:0] SEL_USB_PLL  = 3'h1;
	localparam logic [2:0] SEL_CORE     = 3'h2;
	localparam logic [2:0] SEL_SYS_BUS  = 3'h3;
	localparam logic [2:0] SEL_PERI_BUS = 3'h4;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned MIN_RESET_CORE_CYCLES = 4;
	localparam int unsigned RESET_STRETCH_CYCLES  = 4;
	localparam int unsigned STRETCH_W             = 3;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic mainPll;
		logic usbPll;
		logic core;
		logic sysBus;
		logic periBus;
	} clock_taps_s;

	typedef struct packed {
		logic mainPllRef;
		logic usbPllRef;
	} pll_refs_s;

	typedef enum logic [2:0] {
		PWR_ON    = 3'h1,
		PWR_SLEEP = 3'h2,
		PWR_WAKE  = 3'h4
	} power_state_e;

endpackage

// *** testbench/clock_source_reset_select_asserts.sv ***
`timescale 1ns/100ps
module clock_source_reset_select_asserts #(
	parameter int unsigned NUM_CLK_OUT = 2 // Pins
) (
	input wire logic clk, // In
	input wire logic reset, // In
	input wire logic resetInputN, // In
	input wire logic watchdogResetN, // In
	input wire logic softwareResetReq, // In
	input wire logic [1:0] clockModeStraps, // In
	input wire logic batteryFaultN, // In
	input wire logic sleepReq, // In
	input wire logic wakeReq, // In
	input wire clock_source_reset_select_pkg::clock_taps_s clockTaps, // In
	input wire logic [NUM_CLK_OUT*3-1:0] clockOutSelect, // In
	input wire logic [NUM_CLK_OUT-1:0] clockOutputPin, // In
	input wire clock_source_reset_select_pkg::pll_refs_s pllRefs, // In
	input wire logic resetOutputN, // In
	input wire logic corePowerEnable, // In
	input wire logic asleep // In
);
	logic [NUM_CLK_OUT-1:0] expPin;
	always_comb begin
		for (int i = 0; i < NUM_CLK_OUT; i++) begin
			case (clockOutSelect[i*3+:3])
				3'h0: expPin[i] = clockTaps.mainPll;
				3'h1: expPin[i] = clockTaps.usbPll;
				3'h2: expPin[i] = clockTaps.core;
				3'h3: expPin[i] = clockTaps.sysBus;
				default: expPin[i] = clockTaps.periBus;
			endcase
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset || !resetInputN);
	sequence s_sleepAsk; !asleep && sleepReq; endsequence
	sequence s_wakeAsk; asleep && wakeReq && batteryFaultN; endsequence
	property p_refs; disable iff (1'b0) (reset || !resetInputN) |=> pllRefs == $past(clockModeStraps); endproperty
	property p_hold; 1'b1 |=> $stable(pllRefs); endproperty
	property p_clk; disable iff (reset) resetInputN |=> clockOutputPin == $past(expPin); endproperty
	property p_rst; disable iff (1'b0) (reset || !resetInputN) |=> !clockOutputPin && corePowerEnable && !asleep; endproperty
	property p_rstout; disable iff (reset) 1'b1 |=> resetOutputN == $past(resetInputN & watchdogResetN & softwareResetReq); endproperty
	property p_batt; asleep && !batteryFaultN && $past(!batteryFaultN) |=> asleep; endproperty
	property p_sleep; s_sleepAsk |-> ##2 (asleep && !corePowerEnable); endproperty
	property p_wake; s_wakeAsk |-> ##[1:3] (!asleep && corePowerEnable); endproperty
	a_refs: assert property (p_refs) else $error("pll refs wrong");
	a_hold: assert property (p_hold) else $error("pll refs moved");
	a_clk: assert property (p_clk) else $error("clock pin wrong");
	a_rst: assert property (p_rst) else $error("reset state wrong");
	a_rstout: assert property (p_rstout) else $error("reset out wrong");
	a_batt: assert property (p_batt) else $error("woke on low battery");
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	a_wake: assert property (p_wake) else $error("wake not done");
endmodule

// *** testbench/tap_source.sv ***
`timescale 1ns/100ps
module tap_source (
	input  wire logic                                  clk,  // Clock
	output clock_source_reset_select_pkg::clock_taps_s taps  // Source levels
);
	initial taps = 5'h00;
	always @(posedge clk) taps <= {taps[3:0], ~taps[4]};
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb;
	logic clk = 0, reset = 1, resetInputN = 1, watchdogResetN = 1, softwareResetReq = 1;
	logic batteryFaultN = 1, sleepReq = 0, wakeReq = 0, resetOutputN, corePowerEnable, asleep;
	logic [1:0] clockModeStraps = 2'h0, clockOutputPin;
	logic [5:0] clockOutSelect = 6'h00;
	clock_source_reset_select_pkg::clock_taps_s clockTaps, t;
	clock_source_reset_select_pkg::pll_refs_s pllRefs;
	int fails = 0, totalChecks = 0, cycles = 0;
	always #2.5 clk = ~clk;
	tap_source i_taps (.clk(clk), .taps(clockTaps));
	clock_source_reset_select #(.NUM_CLK_OUT(2)) i_dut (.clk(clk), .reset(reset),
		.resetInputN(resetInputN), .watchdogResetN(watchdogResetN),
		.softwareResetReq(softwareResetReq), .clockModeStraps(clockModeStraps),
		.batteryFaultN(batteryFaultN), .sleepReq(sleepReq), .wakeReq(wakeReq),
		.clockTaps(clockTaps), .clockOutSelect(clockOutSelect), .clockOutputPin(clockOutputPin),
		.pllRefs(pllRefs), .resetOutputN(resetOutputN), .corePowerEnable(corePowerEnable),
		.asleep(asleep));
	function automatic int pick(input int v);
		return v > 3 ? 0 : 4 - v;
	endfunction
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [4:0] seen, input logic [4:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("Checks %0d, mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		step(4);
		reset = 0;
		for (int s = 0; s < 4; s++) begin
			clockModeStraps = 2'(s);
			reset = 1;
			step(1);
			chk(pllRefs, 5'(s));
			reset = 0;
			clockModeStraps = ~2'(s);
			step(3);
			chk(pllRefs, 5'(s));
		end
		for (int s = 0; s < 8; s++) begin
			clockOutSelect = {3'(s), 3'(7 - s)};
			t = clockTaps;
			step(1);
			chk(clockOutputPin, {t[pick(s)], t[pick(7 - s)]});
		end
		for (int i = 0; i < 8; i++) begin
			{resetInputN, watchdogResetN, softwareResetReq} = 3'(i);
			step(1);
			chk(resetOutputN, i == 7);
		end
		sleepReq = 1;
		step(1);
		sleepReq = 0;
		step(1);
		chk({asleep, corePowerEnable}, 5'h02);
		batteryFaultN = 0;
		wakeReq = 1;
		step(4);
		chk(asleep, 5'h01);
		batteryFaultN = 1;
		step(3);
		wakeReq = 0;
		chk({asleep, corePowerEnable}, 5'h01);
		sleepReq = 1;
		step(1);
		sleepReq = 0;
		step(1);
		resetInputN = 0;
		step(4);
		resetInputN = 1;
		chk({clockOutputPin, asleep, corePowerEnable}, 5'h01);
		tally_and_finish();
	end
endmodule
bind clock_source_reset_select clock_source_reset_select_asserts #(.NUM_CLK_OUT(NUM_CLK_OUT)) i_chk (
	.clk(clk), .reset(reset), .resetInputN(resetInputN), .watchdogResetN(watchdogResetN),
	.softwareResetReq(softwareResetReq), .clockModeStraps(clockModeStraps),
	.batteryFaultN(batteryFaultN), .sleepReq(sleepReq), .wakeReq(wakeReq),
	.clockTaps(clockTaps), .clockOutSelect(clockOutSelect), .clockOutputPin(clockOutputPin),
	.pllRefs(pllRefs), .resetOutputN(resetOutputN), .corePowerEnable(corePowerEnable),
	.asleep(asleep));
